// ---- common/smc_pkg.sv ----
package smc_pkg;

   // Register port widths.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets.
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_CLKSEL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_CLKAUX = 4'h3;
   localparam logic [3:0] ADDR_MODEM  = 4'h5;

   // Clock source encodings for the receive and transmit selections.
   localparam logic [1:0] SRC_INPIN = 2'h0;
   localparam logic [1:0] SRC_BIDIR = 2'h1;
   localparam logic [1:0] SRC_BRG   = 2'h2;
   localparam logic [1:0] SRC_DPLL  = 2'h3;

   // Encodings of what the two-way clock pin carries as an output.
   localparam logic [1:0] OUT_DPLL  = 2'h0;
   localparam logic [1:0] OUT_OSC   = 2'h1;
   localparam logic [1:0] OUT_BRG   = 2'h2;
   localparam logic [1:0] OUT_TXCLK = 2'h3;

   // Receive clock multiple codes and their divider terminal counts.
   localparam logic [1:0] MULT_X1  = 2'h0;
   localparam logic [1:0] MULT_X16 = 2'h1;
   localparam logic [1:0] MULT_X32 = 2'h2;
   localparam logic [1:0] MULT_X64 = 2'h3;
   localparam logic [5:0] LIM_X1   = 6'h00;
   localparam logic [5:0] LIM_X16  = 6'h0F;
   localparam logic [5:0] LIM_X32  = 6'h1F;
   localparam logic [5:0] LIM_X64  = 6'h3F;

   // Least idle spacing of a bus master between accesses, in core clocks.
   localparam int RECOVERY_CORE_CLOCKS = 4;

   // Mode register layout.
   typedef struct packed {
      logic       dcd_ie;
      logic       cts_ie;
      logic       rx_en;
      logic       tx_en;
      logic [1:0] mult;
      logic       auto_en;
      logic       async_mode;
   } smc_mode_s;

   // Clock selection register layout.
   typedef struct packed {
      logic       rsv;
      logic       bid_out;
      logic [1:0] bid_sel;
      logic [1:0] tx_sel;
      logic [1:0] rx_sel;
   } smc_clksel_s;

   // Auxiliary clock routing of the input-only clock pin.
   typedef struct packed {
      logic [5:0] rsv;
      logic       inpin_dpll;
      logic       inpin_brg;
   } smc_clkaux_s;

   // Modem control bits of write_register_five.
   typedef struct packed {
      logic       dtr;
      logic [4:0] rsv;
      logic       rts;
      logic       rsv0;
   } smc_modem_s;

   // Status register layout.
   typedef struct packed {
      logic int_req;
      logic rx_enable;
      logic tx_enable;
      logic tx_empty;
      logic dcd_chg;
      logic cts_chg;
      logic dcd_level;
      logic cts_level;
   } smc_status_s;

   // Reset values.
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] CLKSEL_RST = 8'h00;
   localparam logic [7:0] CLKAUX_RST = 8'h00;
   localparam logic [7:0] MODEM_RST  = 8'h00;

endpackage

// ---- core/smc_core.sv ----
// Overview of operation
// R01: Two-way clock pin: clock input or selected output.
// R02: Input clock pin feeds rx, tx, BRG, DPLL.
// R03: Async receive clock divided by 1/16/32/64.
// R04: Auto enable: low clear-to-send enables transmitter.
// R05: Detect both clear-to-send edges, may interrupt.
// R06: Auto enable: carrier detect gates receiver enable.
// R07: Detect both carrier-detect edges, may interrupt.
// R08: Request-to-send bit set drives output low.
// R09: Async auto: output rises only once transmitter empty.
// R10: Otherwise request-to-send output follows its bit.
// R11: Terminal-ready output follows its bit.
// R12: DMA request routed to internal multiplexer.
// R13: Wait drives shared active-low wait, wired-OR.
// R14: Master leaves four core clocks between accesses.
// R15: Edge latches pending flag until software clears.
// R16: Clock selections change by program, independently.
module smc_core (
   // System clock and reset.
   input  wire logic              CLK_SYS_IN,
   input  wire logic              SRST_IN,
   // Register port.
   input  wire logic [3:0]        REG_ADDR_IN,
   input  wire logic [7:0]        REG_WDATA_IN,
   input  wire logic              REG_WR_IN,
   input  wire logic              REG_RD_IN,
   output logic      [7:0]        REG_RDATA_OUT,
   // Clock pins.
   input  wire logic              INPUT_CLOCK_PIN_IN,
   input  wire logic              BIDIR_CLOCK_PIN_IN,
   output logic                   BIDIR_CLOCK_PIN_OUT,
   output logic                   BIDIR_CLOCK_PIN_OE_OUT,
   // Internal clock ticks and transmitter state.
   input  wire logic              BRG_TICK_IN,
   input  wire logic              DPLL_TICK_IN,
   input  wire logic              OSC_TICK_IN,
   input  wire logic              TX_EMPTY_IN,
   output logic                   RX_SAMPLE_OUT,
   output logic                   TX_CLK_TICK_OUT,
   output logic                   BRG_SRC_TICK_OUT,
   output logic                   DPLL_SRC_TICK_OUT,
   // Modem pins.
   input  wire logic              CLEAR_TO_SEND_N_IN,
   input  wire logic              CARRIER_DETECT_N_IN,
   output logic                   REQUEST_TO_SEND_N_OUT,
   output logic                   TERMINAL_READY_N_OUT,
   output logic                   TX_ENABLE_OUT,
   output logic                   RX_ENABLE_OUT,
   output logic                   INT_REQ_OUT,
   // Internal wait and DMA routing.
   input  wire logic              CORE_WAIT_IN,
   input  wire logic              CORE_DMA_REQ_IN,
   output logic                   WAIT_N_OUT,
   output logic                   WAIT_N_OE_OUT,
   output logic                   DMA_REQ_OUT
);

   smc_pkg::smc_mode_s   mode;
   smc_pkg::smc_clksel_s clksel;
   smc_pkg::smc_clkaux_s clkaux;
   smc_pkg::smc_modem_s  write_register_five;
   smc_pkg::smc_status_s status;
   smc_pkg::smc_status_s clr;
   logic       cts_chg;
   logic       dcd_chg;
   logic [1:0] link_rst;
   logic       link_tgl;
   logic [2:0] inpin_sync;
   logic [2:0] bid_sync;
   logic [2:0] cts_sync;
   logic [2:0] dcd_sync;
   logic       inpin_evt;
   logic       bid_evt;
   logic       cts_evt;
   logic       dcd_evt;
   logic       rx_evt;
   logic       tx_evt;
   logic       out_evt;
   logic [5:0] rx_cnt;
   logic [5:0] rx_lim;
   logic       next_tx_enable;
   logic       next_rx_enable;
   logic       next_rts_n;

   // Register writes; each register changes only when software writes it.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         mode   <= smc_pkg::MODE_RST;
         clksel <= smc_pkg::CLKSEL_RST;
         clkaux <= smc_pkg::CLKAUX_RST;
         write_register_five <= smc_pkg::MODEM_RST;
      end else if (REG_WR_IN) begin
         // R16: program-controlled selection
         unique case (REG_ADDR_IN)
            smc_pkg::ADDR_MODE:   mode   <= REG_WDATA_IN;
            smc_pkg::ADDR_CLKSEL: clksel <= REG_WDATA_IN;
            smc_pkg::ADDR_CLKAUX: clkaux <= REG_WDATA_IN;
            smc_pkg::ADDR_MODEM:  write_register_five <= REG_WDATA_IN;
            default: ;
         endcase
      end
   end

   // Status view and write-one-to-clear mask.
   always_comb begin
      status           = '0;
      status.cts_level = cts_sync[1];
      status.dcd_level = dcd_sync[1];
      status.cts_chg   = cts_chg;
      status.dcd_chg   = dcd_chg;
      status.tx_empty  = TX_EMPTY_IN;
      status.tx_enable = TX_ENABLE_OUT;
      status.rx_enable = RX_ENABLE_OUT;
      status.int_req   = INT_REQ_OUT;
      clr = (REG_WR_IN && REG_ADDR_IN == smc_pkg::ADDR_STATUS) ?
            REG_WDATA_IN : '0;
   end

   // Read data stands in the cycle after the read strobe only.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN || !REG_RD_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else begin
         unique case (REG_ADDR_IN)
            smc_pkg::ADDR_MODE:   REG_RDATA_OUT <= mode;
            smc_pkg::ADDR_CLKSEL: REG_RDATA_OUT <= clksel;
            smc_pkg::ADDR_STATUS: REG_RDATA_OUT <= status;
            smc_pkg::ADDR_CLKAUX: REG_RDATA_OUT <= clkaux;
            smc_pkg::ADDR_MODEM:  REG_RDATA_OUT <= write_register_five;
            default:              REG_RDATA_OUT <= 8'h00;
         endcase
      end
   end

   // Link domain reset, released two link clocks after the system reset.
   always_ff @(posedge INPUT_CLOCK_PIN_IN) begin
      link_rst <= {link_rst[0], SRST_IN};
   end

   // Link domain turns each rising input pin clock edge into a toggle.
   always_ff @(posedge INPUT_CLOCK_PIN_IN) begin
      if (link_rst[1]) begin
         link_tgl <= 1'b0;
      end else begin
         link_tgl <= ~link_tgl;
      end
   end

   // Synchronisers; the third stage only serves edge detection.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         inpin_sync <= 3'h0;
         bid_sync   <= 3'h0;
         cts_sync   <= 3'h7;
         dcd_sync   <= 3'h7;
      end else begin
         inpin_sync <= {inpin_sync[1:0], link_tgl};
         bid_sync   <= {bid_sync[1:0], BIDIR_CLOCK_PIN_IN};
         cts_sync   <= {cts_sync[1:0], CLEAR_TO_SEND_N_IN};
         dcd_sync   <= {dcd_sync[1:0], CARRIER_DETECT_N_IN};
      end
   end

   // Clock events; the two-way pin counts only while it is an input.
   assign inpin_evt = inpin_sync[2] ^ inpin_sync[1];
   assign bid_evt   = bid_sync[1] & ~bid_sync[2] & ~clksel.bid_out;
   assign cts_evt   = cts_sync[2] ^ cts_sync[1];
   assign dcd_evt   = dcd_sync[2] ^ dcd_sync[1];

   // Independent receive, transmit and pin output source selection.
   always_comb begin
      // R01: two-way pin as input source
      // R02: input pin as rx or tx
      unique case (clksel.rx_sel)
         smc_pkg::SRC_INPIN: rx_evt = inpin_evt;
         smc_pkg::SRC_BIDIR: rx_evt = bid_evt;
         smc_pkg::SRC_BRG:   rx_evt = BRG_TICK_IN;
         smc_pkg::SRC_DPLL:  rx_evt = DPLL_TICK_IN;
      endcase
      unique case (clksel.tx_sel)
         smc_pkg::SRC_INPIN: tx_evt = inpin_evt;
         smc_pkg::SRC_BIDIR: tx_evt = bid_evt;
         smc_pkg::SRC_BRG:   tx_evt = BRG_TICK_IN;
         smc_pkg::SRC_DPLL:  tx_evt = DPLL_TICK_IN;
      endcase
      unique case (clksel.bid_sel)
         smc_pkg::OUT_DPLL:  out_evt = DPLL_TICK_IN;
         smc_pkg::OUT_OSC:   out_evt = OSC_TICK_IN;
         smc_pkg::OUT_BRG:   out_evt = BRG_TICK_IN;
         smc_pkg::OUT_TXCLK: out_evt = tx_evt;
      endcase
      // R03: divider set by the multiple
      unique case (mode.mult)
         smc_pkg::MULT_X1:  rx_lim = smc_pkg::LIM_X1;
         smc_pkg::MULT_X16: rx_lim = smc_pkg::LIM_X16;
         smc_pkg::MULT_X32: rx_lim = smc_pkg::LIM_X32;
         smc_pkg::MULT_X64: rx_lim = smc_pkg::LIM_X64;
      endcase
      if (!mode.async_mode) begin
         rx_lim = smc_pkg::LIM_X1;
      end
   end

   // R03: receive clock multiple divider
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         rx_cnt        <= 6'h00;
         RX_SAMPLE_OUT <= 1'b0;
      end else begin
         RX_SAMPLE_OUT <= rx_evt && rx_cnt >= rx_lim;
         if (rx_evt) begin
            rx_cnt <= (rx_cnt >= rx_lim) ? 6'h00 : rx_cnt + 6'h01;
         end
      end
   end

   // Clock ticks handed to the transmitter, BRG and DPLL.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         TX_CLK_TICK_OUT   <= 1'b0;
         BRG_SRC_TICK_OUT  <= 1'b0;
         DPLL_SRC_TICK_OUT <= 1'b0;
      end else begin
         TX_CLK_TICK_OUT   <= tx_evt;
         // R02: input pin as BRG or DPLL source
         BRG_SRC_TICK_OUT  <= inpin_evt & clkaux.inpin_brg;
         DPLL_SRC_TICK_OUT <= inpin_evt & clkaux.inpin_dpll;
      end
   end

   // R01: two-way pin output drive
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         BIDIR_CLOCK_PIN_OUT    <= 1'b0;
         BIDIR_CLOCK_PIN_OE_OUT <= 1'b0;
      end else begin
         BIDIR_CLOCK_PIN_OE_OUT <= clksel.bid_out;
         if (!clksel.bid_out) begin
            BIDIR_CLOCK_PIN_OUT <= 1'b0;
         end else if (out_evt) begin
            BIDIR_CLOCK_PIN_OUT <= ~BIDIR_CLOCK_PIN_OUT;
         end
      end
   end

   // Enable gating and request-to-send next state.
   always_comb begin
      // R04: clear-to-send auto enable
      next_tx_enable = mode.tx_en & (~mode.auto_en | ~cts_sync[1]);
      // R06: carrier-detect auto enable
      next_rx_enable = mode.rx_en & (~mode.auto_en | ~dcd_sync[1]);
      next_rts_n     = REQUEST_TO_SEND_N_OUT;
      if (write_register_five.rts) begin
         // R08: bit set drives low
         next_rts_n = 1'b0;
      end else if (mode.async_mode && mode.auto_en) begin
         // R09: rise after transmitter empties
         if (TX_EMPTY_IN) begin
            next_rts_n = 1'b1;
         end
      end else begin
         // R10: plain output follows bit
         next_rts_n = 1'b1;
      end
   end

   // Modem control outputs.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         TX_ENABLE_OUT         <= 1'b0;
         RX_ENABLE_OUT         <= 1'b0;
         REQUEST_TO_SEND_N_OUT <= 1'b1;
         TERMINAL_READY_N_OUT  <= 1'b1;
      end else begin
         TX_ENABLE_OUT         <= next_tx_enable;
         RX_ENABLE_OUT         <= next_rx_enable;
         REQUEST_TO_SEND_N_OUT <= next_rts_n;
         // R11: terminal-ready follows bit
         TERMINAL_READY_N_OUT  <= ~write_register_five.dtr;
      end
   end

   // R15: pending flags, set wins over clear
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         cts_chg     <= 1'b0;
         dcd_chg     <= 1'b0;
         INT_REQ_OUT <= 1'b0;
      end else begin
         // R05: both clear-to-send edges
         cts_chg     <= cts_evt | (cts_chg & ~clr.cts_chg);
         // R07: both carrier-detect edges
         dcd_chg     <= dcd_evt | (dcd_chg & ~clr.dcd_chg);
         INT_REQ_OUT <= (cts_chg & mode.cts_ie) | (dcd_chg & mode.dcd_ie);
      end
   end

   // Wait and DMA request routing.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         WAIT_N_OE_OUT <= 1'b0;
         WAIT_N_OUT    <= 1'b0;
         DMA_REQ_OUT   <= 1'b0;
      end else begin
         // R13: open-drain share of wait
         WAIT_N_OE_OUT <= CORE_WAIT_IN;
         WAIT_N_OUT    <= 1'b0;
         // R12: internal DMA request route
         DMA_REQ_OUT   <= CORE_DMA_REQ_IN;
      end
   end

   // Checks on the system clock domain.
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (SRST_IN);

   rts_set_a: assert property ( // R08
      write_register_five.rts |=> !REQUEST_TO_SEND_N_OUT)
      else $error("request-to-send not low with bit set");
   rts_hold_a: assert property ( // R09
      mode.async_mode && mode.auto_en && !write_register_five.rts &&
      !TX_EMPTY_IN && !REQUEST_TO_SEND_N_OUT |=> !REQUEST_TO_SEND_N_OUT)
      else $error("request-to-send rose before transmitter empty");
   rts_follow_a: assert property ( // R10
      !(mode.async_mode && mode.auto_en) |=>
      REQUEST_TO_SEND_N_OUT == !$past(write_register_five.rts))
      else $error("request-to-send does not follow its bit");
   dtr_follow_a: assert property ( // R11
      ##1 TERMINAL_READY_N_OUT == !$past(write_register_five.dtr))
      else $error("terminal-ready does not follow its bit");
   tx_gate_a: assert property ( // R04
      mode.auto_en && cts_sync[1] |=> !TX_ENABLE_OUT)
      else $error("transmitter enabled with clear-to-send high");
   rx_gate_a: assert property ( // R06
      mode.rx_en && (!mode.auto_en || !dcd_sync[1]) |=> RX_ENABLE_OUT)
      else $error("receiver not enabled");
   cts_edge_a: assert property ( // R05
      $changed(CLEAR_TO_SEND_N_IN) ##3 1 |-> cts_chg)
      else $error("clear-to-send edge not latched");
   dcd_edge_a: assert property ( // R07
      $changed(CARRIER_DETECT_N_IN) ##3 1 |-> dcd_chg)
      else $error("carrier-detect edge not latched");
   pend_hold_a: assert property ( // R15
      cts_chg && !clr.cts_chg |=> cts_chg)
      else $error("pending flag lost without clear");
   int_req_a: assert property ( // R07
      dcd_chg && mode.dcd_ie |=> INT_REQ_OUT)
      else $error("interrupt request missing");
   rx_div_a: assert property ( // R03
      mode.async_mode && mode.mult == smc_pkg::MULT_X16 &&
      RX_SAMPLE_OUT |-> rx_cnt == 6'h00)
      else $error("receive divider out of step");
   brg_src_a: assert property ( // R02
      inpin_evt && clkaux.inpin_brg |=> BRG_SRC_TICK_OUT)
      else $error("input pin tick not passed to baud generator");
   bid_oe_a: assert property ( // R01
      clksel.bid_out |=> BIDIR_CLOCK_PIN_OE_OUT)
      else $error("two-way pin not driven as output");
   sel_stable_a: assert property ( // R16
      !REG_WR_IN |=> $stable(clksel))
      else $error("clock selection changed without a write");
   dma_route_a: assert property ( // R12
      CORE_DMA_REQ_IN |=> DMA_REQ_OUT)
      else $error("DMA request not routed");
   wait_drive_a: assert property ( // R13
      CORE_WAIT_IN |=> WAIT_N_OE_OUT && !WAIT_N_OUT)
      else $error("wait not pulled low");

   rts_release_c: cover property (
      mode.async_mode && mode.auto_en && $fell(write_register_five.rts)
      ##[1:50] $rose(REQUEST_TO_SEND_N_OUT));
   cts_int_c: cover property ($rose(cts_chg) ##[1:4] INT_REQ_OUT);
   rx_x64_c: cover property (
      mode.mult == smc_pkg::MULT_X64 && RX_SAMPLE_OUT);
   bid_out_c: cover property (
      BIDIR_CLOCK_PIN_OE_OUT && $changed(BIDIR_CLOCK_PIN_OUT));

endmodule // smc_core

// ---- tb/smc_modem_model.sv ----
// Remote modem and serial line: handshake levels and the link clock.
module smc_modem_model (
   // Bench controls.
   input  wire logic run_in,
   input  wire logic cts_on_in,
   input  wire logic dcd_on_in,
   input  wire logic bid_lvl_in,
   // Two-way clock pin drive from the design.
   input  wire logic pin_out_in,
   input  wire logic pin_oe_in,
   // Lines toward the design.
   output logic      link_clk_out,
   output logic      cts_n_out,
   output logic      dcd_n_out,
   output logic      bid_wire_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // The link clock runs only while a frame is in progress.
   initial begin
      link_clk_out = 1'b0;
      forever begin
         if (run_in) begin
            #16 link_clk_out = ~link_clk_out;
         end else begin
            @(run_in);
         end
      end
   end

   // Handshake lines are active low toward the design.
   assign cts_n_out = ~cts_on_in;
   assign dcd_n_out = ~dcd_on_in;

   // The modem drives the two-way pin only while the design releases it.
   assign bid_wire_out = pin_oe_in ? pin_out_in : bid_lvl_in;
endmodule // smc_modem_model

// ---- tb/tb_serial_modem_control_pins.sv ----
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      err_count++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
   end \
end

module tb_serial_modem_control_pins;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk, rst, wr, rd, tx_empty, core_wait, dma_req, run, bid_lvl;
   logic       link_clk, cts_n, dcd_n, bid_wire, pin_out, pin_oe, bid_q;
   logic       rx_samp, tx_tick, brg_src, dpll_src, rts_n, dtr_n;
   logic       tx_en, rx_en, irq, wait_n, wait_oe, dma_out;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, st, msk, ex;
   logic [2:0] tick;
   logic [1:0] modem_on;
   int         err_count, samples_checked, rx_cnt, tx_cnt, brg_cnt;
   int         dpll_cnt, bid_cnt;
   int         div [4] = '{1, 16, 32, 64};

   // System clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   smc_modem_model modem (
      .run_in(run), .cts_on_in(modem_on[0]), .dcd_on_in(modem_on[1]),
      .bid_lvl_in(bid_lvl), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
      .link_clk_out(link_clk), .cts_n_out(cts_n), .dcd_n_out(dcd_n),
      .bid_wire_out(bid_wire));

   smc_core dut (
      .CLK_SYS_IN(clk), .SRST_IN(rst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata), .INPUT_CLOCK_PIN_IN(link_clk),
      .BIDIR_CLOCK_PIN_IN(bid_wire), .BIDIR_CLOCK_PIN_OUT(pin_out),
      .BIDIR_CLOCK_PIN_OE_OUT(pin_oe), .BRG_TICK_IN(tick[2]),
      .DPLL_TICK_IN(tick[0]), .OSC_TICK_IN(tick[1]),
      .TX_EMPTY_IN(tx_empty), .RX_SAMPLE_OUT(rx_samp),
      .TX_CLK_TICK_OUT(tx_tick), .BRG_SRC_TICK_OUT(brg_src),
      .DPLL_SRC_TICK_OUT(dpll_src), .CLEAR_TO_SEND_N_IN(cts_n),
      .CARRIER_DETECT_N_IN(dcd_n), .REQUEST_TO_SEND_N_OUT(rts_n),
      .TERMINAL_READY_N_OUT(dtr_n), .TX_ENABLE_OUT(tx_en),
      .RX_ENABLE_OUT(rx_en), .INT_REQ_OUT(irq), .CORE_WAIT_IN(core_wait),
      .CORE_DMA_REQ_IN(dma_req), .WAIT_N_OUT(wait_n),
      .WAIT_N_OE_OUT(wait_oe), .DMA_REQ_OUT(dma_out));

   // Counts clock events and pin toggles seen at the design outputs.
   always @(posedge clk) begin
      rx_cnt += rx_samp;
      tx_cnt += tx_tick;
      brg_cnt += brg_src;
      dpll_cnt += dpll_src;
      if (pin_out !== bid_q) bid_cnt++;
      bid_q = pin_out;
   end

   task automatic clr_cnt();
      @(negedge clk);
      rx_cnt = 0;
      tx_cnt = 0;
      brg_cnt = 0;
      dpll_cnt = 0;
      bid_cnt = 0;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wait_cyc(smc_pkg::RECOVERY_CORE_CLOCKS);
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      wait_cyc(smc_pkg::RECOVERY_CORE_CLOCKS);
   endtask

   // Runs the link clock for a frame of n rising edges, then stops it.
   task automatic link_edges(input int n);
      @(negedge clk);
      run = 1'b1;
      repeat (n) @(posedge link_clk);
      run = 1'b0;
      wait_cyc(12);
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", samples_checked,
               err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run time.
   initial begin
      #400000;
      err_count++;
      close_out();
   end

   // Main test sequence.
   initial begin
      {wr, rd, tx_empty, core_wait, dma_req, bid_lvl, bid_q} = 7'h00;
      {addr, wdata, tick, modem_on} = 17'h00000;
      rst = 1'b1;
      run = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // The link domain leaves its reset only on link clock edges.
      wait_cyc(16);
      run = 1'b0;
      wait_cyc(8);
      `CHK("rts_n rst", 1'b1, rts_n)
      `CHK("dtr_n rst", 1'b1, dtr_n)
      foreach (div[i]) begin
         reg_rd(4'(i == 2 ? 5 : i), st);
         `CHK("reset reg", 8'h00, st)
      end
      reg_wr(4'h4, 8'hFF);
      reg_rd(4'h4, st);
      `CHK("unmapped", 8'h00, st)
      reg_wr(smc_pkg::ADDR_CLKAUX, 8'h03);
      for (int m = 0; m < 4; m++) begin
         reg_wr(smc_pkg::ADDR_MODE, {4'h3, 2'(m), 2'h1});
         clr_cnt();
         link_edges(64);
         `CHK("rx samples", 64 / div[m], rx_cnt)
         `CHK("tx ticks", 64, tx_cnt)
         `CHK("brg src", 64, brg_cnt)
         `CHK("dpll src", 64, dpll_cnt)
      end
      reg_wr(smc_pkg::ADDR_MODE, 8'h30);
      reg_wr(smc_pkg::ADDR_CLKSEL, 8'h01);
      clr_cnt();
      repeat (8) begin
         @(posedge clk) bid_lvl <= 1'b1;
         wait_cyc(4);
         @(posedge clk) bid_lvl <= 1'b0;
         wait_cyc(4);
      end
      wait_cyc(8);
      `CHK("bidir in rx", 8, rx_cnt)
      `CHK("bidir oe in", 1'b0, pin_oe)
      for (int s = 0; s < 4; s++) begin
         reg_wr(smc_pkg::ADDR_CLKSEL, {2'h1, 2'(s), 2'h2, 2'(s)});
         clr_cnt();
         for (int i = 0; i < 3; i++) begin
            repeat (4) begin
               @(posedge clk) tick <= 3'h1 << i;
               @(posedge clk) tick <= 3'h0;
            end
         end
         wait_cyc(4);
         `CHK("bidir toggles", 4, bid_cnt)
         `CHK("tx from brg", 4, tx_cnt)
         `CHK("rx source", (s >= 2) ? 4 : 0, rx_cnt)
         `CHK("bidir oe out", 1'b1, pin_oe)
      end
      reg_wr(smc_pkg::ADDR_MODE, 8'hF2);
      for (int k = 0; k < 2; k++) begin
         for (int j = 0; j < 2; j++) begin
            @(posedge clk) modem_on[k] <= (j == 0);
            wait_cyc(8);
            `CHK("auto enable", (j == 0), k ? rx_en : tx_en)
            `CHK("irq on edge", 1'b1, irq)
            msk = 8'h80 | (8'h20 << k) | (8'h04 << k);
            ex = 8'h80 | (j == 0 ? 8'h20 << k : 8'h00) | (8'h04 << k);
            reg_rd(smc_pkg::ADDR_STATUS, st);
            `CHK("status", ex, st & msk)
            reg_wr(smc_pkg::ADDR_STATUS, 8'h04 << k);
            `CHK("irq cleared", 1'b0, irq)
         end
      end
      reg_wr(smc_pkg::ADDR_MODE, 8'hF0);
      `CHK("tx no auto", 1'b1, tx_en)
      `CHK("rx no auto", 1'b1, rx_en)
      reg_wr(smc_pkg::ADDR_MODE, 8'h00);
      reg_wr(smc_pkg::ADDR_MODEM, 8'h82);
      `CHK("rts set", 1'b0, rts_n)
      `CHK("dtr set", 1'b0, dtr_n)
      reg_rd(smc_pkg::ADDR_MODEM, st);
      `CHK("modem reg read", 8'h82, st)
      reg_wr(smc_pkg::ADDR_MODEM, 8'h00);
      `CHK("rts sync", 1'b1, rts_n)
      `CHK("dtr clear", 1'b1, dtr_n)
      reg_wr(smc_pkg::ADDR_MODE, 8'h03);
      reg_wr(smc_pkg::ADDR_MODEM, 8'h02);
      reg_wr(smc_pkg::ADDR_MODEM, 8'h00);
      wait_cyc(8);
      `CHK("rts held", 1'b0, rts_n)
      @(posedge clk) tx_empty <= 1'b1;
      wait_cyc(3);
      `CHK("rts empty", 1'b1, rts_n)
      @(posedge clk) tx_empty <= 1'b0;
      reg_wr(smc_pkg::ADDR_MODE, 8'h01);
      reg_wr(smc_pkg::ADDR_MODEM, 8'h02);
      reg_wr(smc_pkg::ADDR_MODEM, 8'h00);
      `CHK("rts no auto", 1'b1, rts_n)
      @(posedge clk) {core_wait, dma_req} <= 2'h3;
      wait_cyc(2);
      `CHK("wait oe", 1'b1, wait_oe)
      `CHK("wait level", 1'b0, wait_n)
      `CHK("dma on", 1'b1, dma_out)
      @(posedge clk) {core_wait, dma_req} <= 2'h0;
      wait_cyc(2);
      `CHK("wait off", 1'b0, wait_oe)
      `CHK("dma off", 1'b0, dma_out)
      close_out();
   end
endmodule // tb_serial_modem_control_pins
